/* inc/ttc_defines.vh */
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH

// APB register byte offsets.
`define TTC_OFS_MISC_EN 12'h000
`define TTC_OFS_THR_CTL 12'h004
`define TTC_OFS_STATUS 12'h008
`define TTC_OFS_PERF_REQ 12'h00c
`define TTC_OFS_CAPS 12'h010
`define TTC_OFS_CFG 12'h014

// Enable register fields.
`define TTC_MISC_DCT_EN 3
`define TTC_MISC_FRT_EN 13

// Throttle control register fields.
`define TTC_THR_SEL 16
`define TTC_THR_OP_HI 15
`define TTC_THR_OP_LO 0

// Status register fields.
`define TTC_ST_HOT 0
`define TTC_ST_LOG 1
`define TTC_ST_HALT 2
`define TTC_ST_ENGAGED 3
`define TTC_ST_PERF_PEND 4

// Capability word fields.
`define TTC_CAP_DCT 29
`define TTC_CAP_FRT 8

// Configuration register fields.
`define TTC_CFG_LATE 0
`define TTC_CFG_DUTY_HI 3
`define TTC_CFG_DUTY_LO 1

// Reset values.
`define TTC_DUTY_RST 3'h4
`define TTC_OP_RST 16'h0000

// Minimum engage time in microseconds and clock rate in MHz.
`define TTC_MIN_ENGAGE_US 1000
`define TTC_CLK_MHZ 100

`endif

/* design/ttc_throttle.v */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "ttc_defines.vh"

// Notes on behaviour
// [RULE_01] Catastrophic trip halts core until reset
// [RULE_02] Monitor trip sits below catastrophic limit
// [RULE_03] Duty mode gates clock internally, never external pin
// [RULE_04] Duty mode needs enable bit 3; reset clears
// [RULE_05] Duty means share of time clock runs
// [RULE_06] Frequency mode lowers frequency and voltage
// [RULE_07] Both modes share one monitor trip input
// [RULE_08] Early method: bit16 and bit3 give frequency mode
// [RULE_09] Early method: bit3 with bit16 clear gives duty
// [RULE_10] Later method: bit 13 enables frequency mode
// [RULE_11] Frequency mode targets operating point bits 15:0
// [RULE_12] Firmware enables at least one mode
// [RULE_13] Firmware enables exactly one mode
// [RULE_14] Software never clears enables or operating point
// [RULE_15] Capability bit 29 reports duty mode
// [RULE_16] Extended capability bit 8 reports frequency mode
// [RULE_17] Status bit 0 shows hot and throttling
// [RULE_18] Engage at least 1 ms, release below hysteresis
// [RULE_19] Perf change deferred while frequency mode engaged
// [RULE_20] No mode enabled: trip changes nothing; the code still sets the sticky status log bit on a trip
module ttc_throttle #(
  parameter MIN_ENGAGE_CYC = `TTC_MIN_ENGAGE_US * `TTC_CLK_MHZ,
  parameter CNT_W = 17,
  parameter OP_W = 16
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Sensor inputs, asynchronous to clk.
  input wire catastrophic_trip,
  input wire monitor_trip,
  input wire monitor_below_hyst,
  // Core controls.
  output reg core_halt,
  output reg core_clk_gate_en,
  output reg freq_reduction_active,
  output reg [OP_W-1:0] operating_point,
  output reg perf_change_start,
  output reg [OP_W-1:0] perf_target
);

  ////////////////////////////////////////////////////////////////////////
  // Sensor synchronisers.
  reg [1:0] cat_sync;
  reg [1:0] mon_sync;
  reg [1:0] hyst_sync;
  wire cat_hot = cat_sync[1];
  wire mon_hot = mon_sync[1];
  wire mon_cool = hyst_sync[1];

  // Each sensor passes two flops; only stage two is read.
  always @(posedge clk) begin
    if (sys_rst) begin
      cat_sync <= 2'h0;
      mon_sync <= 2'h0;
      hyst_sync <= 2'h0;
    end else begin
      cat_sync <= {cat_sync[0], catastrophic_trip};
      mon_sync <= {mon_sync[0], monitor_trip}; // [RULE_07]
      hyst_sync <= {hyst_sync[0], monitor_below_hyst};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers.
  reg dct_en;
  reg frt_en_late;
  reg mode_select_flag;
  reg [OP_W-1:0] target_op;
  reg late_method;
  reg [2:0] duty_sel;
  reg status_log;
  reg [OP_W-1:0] perf_req;
  reg perf_pend;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~pwrite;
  wire sel_misc = (paddr == `TTC_OFS_MISC_EN);
  wire sel_thr = (paddr == `TTC_OFS_THR_CTL);
  wire sel_st = (paddr == `TTC_OFS_STATUS);
  wire sel_perf = (paddr == `TTC_OFS_PERF_REQ);
  wire sel_caps = (paddr == `TTC_OFS_CAPS);
  wire sel_cfg = (paddr == `TTC_OFS_CFG);
  wire mapped = sel_misc | sel_thr | sel_st | sel_perf | sel_caps | sel_cfg;

  // Zero wait states; unmapped addresses return an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Resolved mode enables for the early and later methods.
  wire frt_mode = late_method ? frt_en_late
                : (dct_en & mode_select_flag); // [RULE_08] [RULE_10]
  wire dct_mode = late_method ? (dct_en & ~frt_en_late)
                : (dct_en & ~mode_select_flag); // [RULE_04] [RULE_09]

  ////////////////////////////////////////////////////////////////////////
  // Engage state machine.
  localparam ST_IDLE = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_WAIT = 3'b100;
  reg [2:0] state;
  reg [CNT_W-1:0] hold_cnt;
  wire engaged = (state != ST_IDLE);
  wire any_mode = dct_mode | frt_mode;

  // Trip engages only with a mode enabled; hold then wait for cooling.
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      hold_cnt <= {CNT_W{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          if (mon_hot & any_mode) begin // [RULE_02] [RULE_20]
            state <= ST_HOLD;
            hold_cnt <= MIN_ENGAGE_CYC[CNT_W-1:0] - 1'b1;
          end
        end
        ST_HOLD: begin
          if (hold_cnt == {CNT_W{1'b0}})
            state <= ST_WAIT; // [RULE_18]
          else
            hold_cnt <= hold_cnt - 1'b1;
        end
        ST_WAIT: begin
          if (mon_cool & ~mon_hot)
            state <= ST_IDLE; // [RULE_18]
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Duty modulation: eighths of a 8-slot frame, one slot per clock cycle.
  reg [2:0] slot;
  wire [2:0] on_slots = duty_sel;

  // Slot counter steps each cycle; the clock runs for duty_sel slots.
  always @(posedge clk) begin
    if (sys_rst)
      slot <= 3'h0;
    else
      slot <= slot + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Core control outputs.
  always @(posedge clk) begin
    if (sys_rst) begin
      core_halt <= 1'b0;
      core_clk_gate_en <= 1'b1;
      freq_reduction_active <= 1'b0;
      operating_point <= `TTC_OP_RST;
    end else begin
      // Latched halt leaves only by reset.
      if (cat_hot)
        core_halt <= 1'b1; // [RULE_01]
      // Internal gating; share of on-slots is the duty cycle.
      if (engaged & dct_mode)
        core_clk_gate_en <= (slot < on_slots); // [RULE_03] [RULE_05]
      else
        core_clk_gate_en <= 1'b1;
      freq_reduction_active <= engaged & frt_mode; // [RULE_06]
      if (engaged & frt_mode)
        operating_point <= target_op; // [RULE_11]
      else
        operating_point <= perf_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes, status log and deferred performance requests.
  wire frt_busy = engaged & frt_mode;
  wire perf_wr = wr_en & sel_perf;

  always @(posedge clk) begin
    if (sys_rst) begin
      dct_en <= 1'b0;
      frt_en_late <= 1'b0;
      mode_select_flag <= 1'b0;
      target_op <= `TTC_OP_RST;
      late_method <= 1'b0;
      duty_sel <= `TTC_DUTY_RST;
      status_log <= 1'b0;
      perf_req <= `TTC_OP_RST;
      perf_pend <= 1'b0;
      perf_change_start <= 1'b0;
      perf_target <= `TTC_OP_RST;
    end else begin
      perf_change_start <= 1'b0;
      if (wr_en & sel_misc) begin
        dct_en <= pwdata[`TTC_MISC_DCT_EN]; // [RULE_04]
        frt_en_late <= pwdata[`TTC_MISC_FRT_EN]; // [RULE_10]
      end
      if (wr_en & sel_thr) begin
        mode_select_flag <= pwdata[`TTC_THR_SEL]; // [RULE_08]
        target_op <= pwdata[`TTC_THR_OP_HI:`TTC_THR_OP_LO];
      end
      if (wr_en & sel_cfg) begin
        late_method <= pwdata[`TTC_CFG_LATE];
        duty_sel <= pwdata[`TTC_CFG_DUTY_HI:`TTC_CFG_DUTY_LO];
      end
      // Sticky log: a trip in the clearing cycle wins.
      if (mon_hot)
        status_log <= 1'b1;
      else if (wr_en & sel_st & ~pwdata[`TTC_ST_LOG])
        status_log <= 1'b0;
      // Requests wait out frequency throttling before starting.
      if (perf_wr)
        perf_req <= pwdata[OP_W-1:0];
      if (perf_wr & frt_busy) begin
        perf_pend <= 1'b1; // [RULE_19]
      end else if (perf_wr) begin
        perf_change_start <= 1'b1;
        perf_target <= pwdata[OP_W-1:0];
        perf_pend <= 1'b0;
      end else if (perf_pend & ~frt_busy) begin
        perf_change_start <= 1'b1; // [RULE_19]
        perf_target <= perf_req;
        perf_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data mux, registered for the access phase.
  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h0;
    if (sel_misc) begin
      next_prdata[`TTC_MISC_DCT_EN] = dct_en;
      next_prdata[`TTC_MISC_FRT_EN] = frt_en_late;
    end
    if (sel_thr) begin
      next_prdata[`TTC_THR_SEL] = mode_select_flag;
      next_prdata[`TTC_THR_OP_HI:`TTC_THR_OP_LO] = target_op;
    end
    if (sel_st) begin
      next_prdata[`TTC_ST_HOT] = mon_hot & engaged; // [RULE_17]
      next_prdata[`TTC_ST_LOG] = status_log;
      next_prdata[`TTC_ST_HALT] = core_halt;
      next_prdata[`TTC_ST_ENGAGED] = engaged;
      next_prdata[`TTC_ST_PERF_PEND] = perf_pend;
    end
    if (sel_perf)
      next_prdata[OP_W-1:0] = perf_req;
    if (sel_caps) begin
      next_prdata[`TTC_CAP_DCT] = 1'b1; // [RULE_15]
      next_prdata[`TTC_CAP_FRT] = 1'b1; // [RULE_16]
    end
    if (sel_cfg) begin
      next_prdata[`TTC_CFG_LATE] = late_method;
      next_prdata[`TTC_CFG_DUTY_HI:`TTC_CFG_DUTY_LO] = duty_sel;
    end
  end

  // Capture read data in the setup cycle.
  always @(posedge clk) begin
    if (sys_rst)
      prdata <= 32'h0;
    else if (rd_en & ~penable)
      prdata <= next_prdata;
  end

endmodule // ttc_throttle

/* bench/ttc_checker.sv */
`timescale 1ns/1ns
// Watches the core controls of the throttle block.
module ttc_checker #(
  parameter OP_W = 16
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Sensor levels.
  input wire catastrophic_trip,
  input wire monitor_trip,
  // Core controls.
  input wire core_halt,
  input wire core_clk_gate_en,
  input wire freq_reduction_active,
  input wire [OP_W-1:0] operating_point,
  input wire perf_change_start
);
  // All checks share the core clock and pause in reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////
  // Start of a frequency engagement, and a clock stop too long for any duty above zero.
  sequence s_engage;
    $rose(freq_reduction_active);
  endsequence
  sequence s_gate_off8;
    !core_clk_gate_en [*8];
  endsequence
  property p_halt;
    $rose(catastrophic_trip) |-> ##[1:6] core_halt;
  endproperty
  property p_sticky;
    core_halt |=> core_halt;
  endproperty
  property p_duty;
    s_gate_off8 |-> core_halt;
  endproperty
  property p_freq_gate;
    freq_reduction_active && !core_halt |-> core_clk_gate_en;
  endproperty
  property p_trip;
    s_engage |-> $past(monitor_trip, 4);
  endproperty
  property p_min_hold;
    s_engage |-> freq_reduction_active [*8];
  endproperty
  property p_op;
    freq_reduction_active && $past(freq_reduction_active)
      |-> $stable(operating_point);
  endproperty
  property p_defer;
    s_engage |-> !perf_change_start [*4];
  endproperty
  property p_pulse;
    perf_change_start |=> !perf_change_start;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt late");
  a_sticky: assert property (p_sticky)
    else $error("halt dropped");
  a_duty: assert property (p_duty)
    else $error("clock stopped too long");
  a_freq_gate: assert property (p_freq_gate)
    else $error("clock gated in frequency mode");
  a_trip: assert property (p_trip)
    else $error("engaged without trip");
  a_min_hold: assert property (p_min_hold)
    else $error("engagement too short");
  a_op: assert property (p_op)
    else $error("operating point moved");
  a_defer: assert property (p_defer)
    else $error("perf change not deferred");
  a_pulse: assert property (p_pulse)
    else $error("perf pulse too long");
endmodule // ttc_checker

/* bench/ttc_sensor_model.sv */
`timescale 1ns/1ns
// Die sensors whose levels follow the temperature set by the bench.
module ttc_sensor_model #(
  parameter CAT = 8'd125,
  parameter TRIP = 8'd90,
  parameter HYST = 8'd5
) (
  // Clock and die temperature.
  input wire clk,
  input wire [7:0] temp,
  // Sensor levels.
  output logic catastrophic_trip,
  output logic monitor_trip,
  output logic monitor_below_hyst
);
  // Cool die at time zero.
  initial {catastrophic_trip, monitor_trip, monitor_below_hyst} = 3'b001;
  // The monitor trips below the catastrophic limit so throttling acts first.
  always @(posedge clk) begin
    catastrophic_trip <= temp >= CAT;
    monitor_trip <= temp >= TRIP;
    monitor_below_hyst <= temp < TRIP - HYST;
  end
endmodule // ttc_sensor_model

/* bench/thermal_throttle_control_bench.sv */
`timescale 1ns/1ns
`include "ttc_defines.vh"
module thermal_throttle_control_bench;
  logic clk, sys_rst, psel, penable, pwrite, err, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [7:0] temp;
  wire pready, pslverr, cat, mon, hyst, halt, gate, frq, pcs;
  wire [31:0] prdata;
  wire [15:0] op, ptgt;
  integer mismatches = 0, samples_checked = 0, n;
  // Clock and watchdog.
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000 mismatches++;
    results;
  end
  // Block under test and its sensors.
  ttc_throttle #(.MIN_ENGAGE_CYC(20)) dut (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .catastrophic_trip(cat), .monitor_trip(mon), .monitor_below_hyst(hyst),
    .core_halt(halt), .core_clk_gate_en(gate), .freq_reduction_active(frq),
    .operating_point(op), .perf_change_start(pcs), .perf_target(ptgt));
  ttc_sensor_model sens (.clk(clk), .temp(temp), .catastrophic_trip(cat),
    .monitor_trip(mon), .monitor_below_hyst(hyst));
  // Remembers any perf change pulse.
  always @(posedge clk) if (pcs === 1'b1) seen <= 1'b1;
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // One APB transfer, held until pready is seen.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset;
    @(posedge clk);
    temp <= 8'd40;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
  endtask
  task results;
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_idle;
    apb(0, `TTC_OFS_MISC_EN, 0);
    chk(rdata[3], 0);
    apb(0, `TTC_OFS_CAPS, 0);
    chk(rdata[29], 1);
    chk(rdata[8], 1);
    apb(0, 12'h020, 0);
    chk(err, 1);
    temp <= 8'd95;
    tick(20);
    chk({gate, frq, op}, 18'h20000);
    apb(0, `TTC_OFS_STATUS, 0);
    chk(rdata[0], 0);
    chk(rdata[1], 1);
    chk(pready, 1);
  endtask
  task t_duty;
    do_reset;
    apb(1, `TTC_OFS_MISC_EN, 32'h8);
    temp <= 8'd95;
    tick(10);
    n = 0;
    repeat (8) begin
      tick(1);
      n = n + gate;
    end
    chk(n, 4);
    chk(frq, 0);
    apb(0, `TTC_OFS_STATUS, 0);
    chk(rdata[0], 1);
    temp <= 8'd40;
    tick(60);
    apb(0, `TTC_OFS_STATUS, 0);
    chk(rdata[0], 0);
  endtask
  task t_freq;
    do_reset;
    apb(1, `TTC_OFS_THR_CTL, 32'h11234);
    apb(1, `TTC_OFS_MISC_EN, 32'h8);
    temp <= 8'd95;
    tick(8);
    chk({frq, gate, op}, 18'h31234);
    temp <= 8'd40;
    seen = 0;
    apb(1, `TTC_OFS_PERF_REQ, 32'haa);
    tick(5);
    chk({frq, seen}, 2'b10);
    tick(40);
    chk({frq, seen, ptgt}, 18'h100aa);
  endtask
  task t_late;
    do_reset;
    apb(1, `TTC_OFS_CFG, 32'hd);
    apb(1, `TTC_OFS_MISC_EN, 32'h8);
    temp <= 8'd95;
    tick(10);
    n = 0;
    repeat (8) begin
      tick(1);
      n = n + gate;
    end
    chk(n, 6);
    chk(frq, 0);
    do_reset;
    apb(1, `TTC_OFS_CFG, 32'h9);
    apb(1, `TTC_OFS_MISC_EN, 32'h2000);
    temp <= 8'd95;
    tick(8);
    chk({frq, gate}, 2'b11);
  endtask
  task t_cat;
    do_reset;
    temp <= 8'd130;
    tick(8);
    chk(halt, 1);
    temp <= 8'd40;
    tick(10);
    chk(halt, 1);
    do_reset;
    chk(halt, 0);
  endtask
  // Main sequence.
  initial begin
    {sys_rst, psel, penable, pwrite, seen} = 5'b10000;
    paddr = 0;
    pwdata = 0;
    temp = 8'd40;
    do_reset;
    t_idle;
    t_duty;
    t_freq;
    t_late;
    t_cat;
    results;
  end
endmodule // thermal_throttle_control_bench
bind ttc_throttle ttc_checker #(.OP_W(OP_W)) chk_i (.clk(clk),
  .sys_rst(sys_rst), .catastrophic_trip(catastrophic_trip),
  .monitor_trip(monitor_trip), .core_halt(core_halt),
  .core_clk_gate_en(core_clk_gate_en),
  .freq_reduction_active(freq_reduction_active),
  .operating_point(operating_point), .perf_change_start(perf_change_start));
